//--- hdl/opv_validate.v
// OAM endpoint PDU validation: one frame descriptor per cycle in, verdict next cycle.
// Assumes descriptor fields and config ports come from logic on mclk_i.
// Notes on behaviour
// - Level-bypass lookup makes every frame of the flow plain data.
// - Transmit frame kind from header field; only supported Y.1731 PDUs validated.
// - Transmit rejects count, set block-error flag, optionally go to error queue.
// - One shared setting limits error flags and extraction to CCM only.
// - Receive validation only for Y.1731 kind; others are data.
// - Level above endpoint: discard if high-block enabled, else data.
// - Zero-interval CCM discarded; last result kept; change flags; optional extract.
// - Equal level goes on to MAC check; lower level blocked, flagged, extractable.
// - CCM low-level result kept, change flagged; level discards of CCM counted.
// - Destination MAC checked per select; failure blocks, flags, extractable.
// - No version check for linktrace, generic or unknown opcodes.
// - Enabled version check uses one accepted-version set for all opcodes; mismatch blocks, flags.
// - After version, CCM goes to CCM checks, loss PDUs aside, rest valid.
// - CCM identity checks only with CCM hardware processing enabled.
// - Group identifier compare; last result, change flag, discard, extract, count.
// - Peer identifier compare; last result, change flag, discard, extract, count.
// - CCM passing identity checks is valid and clears loss-of-continuity.
// - Interval, priority and TLV checks only report, never invalidate.
// - Interval compare; last result, change flag, optional CCM queue copy, count.
// - Priority compare; no last result, flag on mismatch, optional CCM queue copy.
// - Unknown trailing TLV flags; CCM queue copy once per arming.
// - Every receive validation discard bumps the receive discard count.
// - MAC check against common multicast or own unicast address.
`timescale 1ns/1ps
`default_nettype none
`include "opv_consts.vh"
module opv_validate #(
	parameter CW = 16
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Frame descriptor
	input wire frm_valid_i,
	input wire frm_is_rx_i,
	input wire level_bypass_enable_i,
	input wire [1:0] frame_kind_field_i,
	input wire tx_valid_pdu_i,
	input wire [2:0] pdu_level_i,
	input wire [7:0] pdu_opcode_i,
	input wire [4:0] pdu_version_i,
	input wire pdu_generic_i,
	input wire [47:0] pdu_dmac_i,
	input wire [2:0] pdu_interval_i,
	input wire [2:0] pdu_priority_i,
	input wire [12:0] pdu_peer_id_i,
	input wire [383:0] pdu_group_id_i,
	input wire [7:0] pdu_tlv_type_i,
	// Configuration
	input wire [2:0] endpoint_level_i,
	input wire high_level_block_enable_i,
	input wire [1:0] dest_mac_check_select_i,
	input wire [47:0] mc_mac_i,
	input wire [47:0] uc_mac_i,
	input wire version_check_enable_i,
	input wire [31:0] ver_accept_i,
	input wire error_report_ccm_only_i,
	input wire ccm_hw_enable_i,
	input wire group_id_check_enable_i,
	input wire peer_id_check_enable_i,
	input wire [383:0] group_id_cfg_i,
	input wire [12:0] peer_id_cfg_i,
	input wire [2:0] expected_ccm_interval_i,
	input wire [2:0] expected_ccm_priority_i,
	input wire [`OPV_NFLAGS-1:0] extract_enable_i,
	input wire tlv_rearm_i,
	// Flag control
	input wire [`OPV_NFLAGS-1:0] flag_clear_i,
	input wire [`OPV_NFLAGS-1:0] intr_enable_i,
	// Verdict
	output reg res_valid_o,
	output reg [2:0] result_o,
	output reg cpu_error_queue_o,
	output reg cpu_continuity_queue_o,
	output reg loc_clear_o,
	// Status
	output reg [`OPV_NFLAGS-1:0] flags_o,
	output reg [4:0] last_result_o,
	output reg intr_o,
	output wire [CW-1:0] tx_discard_count_o,
	output wire [CW-1:0] rx_discard_count_o,
	output wire [CW-1:0] level_discard_count_o,
	output wire [CW-1:0] interval_mismatch_count_o,
	output wire [CW-1:0] group_id_error_count_o,
	output wire [CW-1:0] peer_id_error_count_o
);
	// Comb verdict
	reg [2:0] res_next;
	reg [`OPV_NFLAGS-1:0] ev_next;
	reg err_q_next;
	reg ccm_q_next;
	reg loc_next;
	reg tx_disc_next;
	reg rx_disc_next;
	reg lvl_cnt_next;
	reg per_cnt_next;
	reg grp_cnt_next;
	reg peer_cnt_next;
	reg [4:0] last_next;
	reg [4:0] last_upd;
	reg tlv_armed_reg;
	reg tlv_armed_next;
	reg is_ccm;
	reg is_y;
	reg report_ok;
	reg mac_ok;
	reg ver_skip;
	reg ver_ok;
	reg grp_bad;
	reg peer_bad;
	reg [`OPV_NFLAGS-1:0] flags_next;
	always @*
	begin
		res_next = `OPV_RES_DATA;
		ev_next = {`OPV_NFLAGS{1'b0}};
		err_q_next = 1'b0;
		ccm_q_next = 1'b0;
		loc_next = 1'b0;
		tx_disc_next = 1'b0;
		rx_disc_next = 1'b0;
		lvl_cnt_next = 1'b0;
		per_cnt_next = 1'b0;
		grp_cnt_next = 1'b0;
		peer_cnt_next = 1'b0;
		last_next = last_result_o;
		last_upd = last_result_o;
		tlv_armed_next = tlv_armed_reg | tlv_rearm_i;
		is_ccm = (pdu_opcode_i == `OPV_OP_CCM) && !pdu_generic_i;
		is_y = frame_kind_field_i == `OPV_KIND_Y1731;
		report_ok = !error_report_ccm_only_i || is_ccm;
		if (dest_mac_check_select_i == `OPV_DMAC_UC)
			mac_ok = pdu_dmac_i == uc_mac_i;
		else if (dest_mac_check_select_i == `OPV_DMAC_MC)
			mac_ok = pdu_dmac_i == mc_mac_i;
		else if (dest_mac_check_select_i == `OPV_DMAC_EITHER)
			mac_ok = (pdu_dmac_i == uc_mac_i) || (pdu_dmac_i == mc_mac_i);
		else
			mac_ok = 1'b1;
		// Unknown opcodes arrive flagged generic by the classifier
		ver_skip = pdu_generic_i || (pdu_opcode_i == `OPV_OP_LTM) || (pdu_opcode_i == `OPV_OP_LTR);
		ver_ok = ver_skip || !version_check_enable_i || ver_accept_i[pdu_version_i];
		grp_bad = group_id_check_enable_i && (pdu_group_id_i != group_id_cfg_i);
		peer_bad = peer_id_check_enable_i && (pdu_peer_id_i != peer_id_cfg_i);
		if (!frm_valid_i || level_bypass_enable_i || !is_y)
			res_next = `OPV_RES_DATA;
		else if (!frm_is_rx_i)
		begin
			// Transmit checks are done upstream; only the verdict lands here
			if (tx_valid_pdu_i)
				res_next = `OPV_RES_VALID;
			else
			begin
				res_next = `OPV_RES_DISCARD;
				tx_disc_next = 1'b1;
				ev_next[`OPV_FL_TXBLK] = report_ok;
				err_q_next = report_ok && extract_enable_i[`OPV_FL_TXBLK];
			end
		end
		else if (pdu_level_i > endpoint_level_i)
		begin
			if (high_level_block_enable_i)
			begin
				res_next = `OPV_RES_DISCARD;
				ev_next[`OPV_FL_HIGH] = report_ok;
				err_q_next = report_ok && extract_enable_i[`OPV_FL_HIGH];
				lvl_cnt_next = is_ccm;
			end
			else
				res_next = `OPV_RES_DATA;
		end
		else
		begin
			if (is_ccm)
			begin
				last_upd[0] = pdu_interval_i == 3'h0;
				last_upd[1] = pdu_level_i < endpoint_level_i;
				last_next[1:0] = last_upd[1:0];
			end
			if (is_ccm && (pdu_interval_i == 3'h0))
			begin
				res_next = `OPV_RES_DISCARD;
				err_q_next = extract_enable_i[`OPV_FL_ZERO];
			end
			else if (pdu_level_i < endpoint_level_i)
			begin
				res_next = `OPV_RES_DISCARD;
				ev_next[`OPV_FL_LOW] = report_ok;
				err_q_next = report_ok && extract_enable_i[`OPV_FL_LOW];
				lvl_cnt_next = is_ccm;
			end
			else if (!mac_ok)
			begin
				res_next = `OPV_RES_DISCARD;
				ev_next[`OPV_FL_DMAC] = report_ok;
				err_q_next = report_ok && extract_enable_i[`OPV_FL_DMAC];
			end
			else if (!ver_ok)
			begin
				res_next = `OPV_RES_DISCARD;
				ev_next[`OPV_FL_VER] = report_ok;
				err_q_next = report_ok && extract_enable_i[`OPV_FL_VER];
			end
			else if (!pdu_generic_i && ((pdu_opcode_i == `OPV_OP_SLM) || (pdu_opcode_i == `OPV_OP_SLR)
				|| (pdu_opcode_i == `OPV_OP_1SL)))
				res_next = `OPV_RES_SYNLM;
			else if (!is_ccm || !ccm_hw_enable_i)
				res_next = `OPV_RES_VALID;
			else
			begin
				last_next[2] = grp_bad;
				last_next[3] = peer_bad;
				if (grp_bad || peer_bad)
				begin
					res_next = `OPV_RES_DISCARD;
					grp_cnt_next = grp_bad;
					peer_cnt_next = peer_bad;
					err_q_next = (grp_bad && extract_enable_i[`OPV_FL_GRP])
						|| (peer_bad && extract_enable_i[`OPV_FL_PEER]);
				end
				else
				begin
					// Report-only checks below never touch the verdict
					res_next = `OPV_RES_VALID;
					loc_next = 1'b1;
					last_next[4] = pdu_interval_i != expected_ccm_interval_i;
					per_cnt_next = last_next[4];
					ccm_q_next = (last_next[4] && extract_enable_i[`OPV_FL_PER])
						|| ((pdu_priority_i != expected_ccm_priority_i) && extract_enable_i[`OPV_FL_PRIO]);
					ev_next[`OPV_FL_PRIO] = pdu_priority_i != expected_ccm_priority_i;
					if ((pdu_tlv_type_i != 8'h00) && (pdu_tlv_type_i != `OPV_TLV_PORT)
						&& (pdu_tlv_type_i != `OPV_TLV_IFACE))
					begin
						ev_next[`OPV_FL_TLV] = 1'b1;
						if (tlv_armed_next && extract_enable_i[`OPV_FL_TLV])
						begin
							ccm_q_next = 1'b1;
							tlv_armed_next = 1'b0;
						end
					end
				end
			end
		end
		rx_disc_next = frm_is_rx_i && (res_next == `OPV_RES_DISCARD);
		ev_next[`OPV_FL_ZERO] = last_next[0] != last_result_o[0];
		ev_next[`OPV_FL_LOWCH] = last_next[1] != last_result_o[1];
		ev_next[`OPV_FL_GRP] = last_next[2] != last_result_o[2];
		ev_next[`OPV_FL_PEER] = last_next[3] != last_result_o[3];
		ev_next[`OPV_FL_PER] = last_next[4] != last_result_o[4];
		// Priority last result is not stored separately; flag on mismatch
		flags_next = (flags_o & ~flag_clear_i) | ev_next;
	end
	always @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			res_valid_o <= 1'b0;
			result_o <= `OPV_RES_DATA;
			cpu_error_queue_o <= 1'b0;
			cpu_continuity_queue_o <= 1'b0;
			loc_clear_o <= 1'b0;
			flags_o <= {`OPV_NFLAGS{1'b0}};
			last_result_o <= 5'h00;
			intr_o <= 1'b0;
			tlv_armed_reg <= 1'b1;
		end
		else
		begin
			res_valid_o <= frm_valid_i;
			result_o <= res_next;
			cpu_error_queue_o <= err_q_next;
			cpu_continuity_queue_o <= ccm_q_next;
			loc_clear_o <= loc_next;
			flags_o <= flags_next;
			last_result_o <= last_next;
			intr_o <= |(flags_next & intr_enable_i);
			tlv_armed_reg <= tlv_armed_next;
		end
	end
	// Counters
	opv_counter #(.W(CW)) u_txd (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(tx_disc_next), .count_o(tx_discard_count_o));
	opv_counter #(.W(CW)) u_rxd (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(rx_disc_next), .count_o(rx_discard_count_o));
	opv_counter #(.W(CW)) u_lvl (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(lvl_cnt_next), .count_o(level_discard_count_o));
	opv_counter #(.W(CW)) u_per (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(per_cnt_next),
		.count_o(interval_mismatch_count_o));
	opv_counter #(.W(CW)) u_grp (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(grp_cnt_next),
		.count_o(group_id_error_count_o));
	opv_counter #(.W(CW)) u_peer (.mclk_i(mclk_i), .rst_i(rst_i), .inc_i(peer_cnt_next),
		.count_o(peer_id_error_count_o));
endmodule // opv_validate
`default_nettype wire

//--- hdl/opv_consts.vh
// Constants for the OAM PDU validation stage.
// Assumes a single core clock; included by bare name.
`ifndef OPV_CONSTS_VH
`define OPV_CONSTS_VH
`define OPV_KIND_Y1731 2'h1
`define OPV_KIND_SEQ 2'h2
`define OPV_OP_CCM 8'h01
`define OPV_OP_LTR 8'h04
`define OPV_OP_LTM 8'h05
`define OPV_OP_SLR 8'h54
`define OPV_OP_SLM 8'h55
`define OPV_OP_1SL 8'h35
`define OPV_TLV_PORT 8'h02
`define OPV_TLV_IFACE 8'h04
`define OPV_RES_DATA 3'h0
`define OPV_RES_VALID 3'h1
`define OPV_RES_DISCARD 3'h2
`define OPV_RES_SYNLM 3'h3
`define OPV_DMAC_NONE 2'h0
`define OPV_DMAC_UC 2'h1
`define OPV_DMAC_MC 2'h2
`define OPV_DMAC_EITHER 2'h3
`define OPV_FL_TXBLK 0
`define OPV_FL_LOW 1
`define OPV_FL_HIGH 2
`define OPV_FL_DMAC 3
`define OPV_FL_VER 4
`define OPV_FL_TLV 5
`define OPV_FL_ZERO 6
`define OPV_FL_LOWCH 7
`define OPV_FL_GRP 8
`define OPV_FL_PEER 9
`define OPV_FL_PER 10
`define OPV_FL_PRIO 11
`define OPV_NFLAGS 12
`endif

//--- hdl/opv_counter.v
// Saturating event counter, reset to zero.
// Assumes inc_i is a one-cycle pulse on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module opv_counter #(
	parameter W = 16
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Event
	input wire inc_i,
	output reg [W-1:0] count_o
);
	always @(posedge mclk_i)
	begin
		if (rst_i)
			count_o <= {W{1'b0}};
		else if (inc_i && (count_o != {W{1'b1}}))
			count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
	end
endmodule // opv_counter
`default_nettype wire

//--- bench/opv_validate_properties.sv
// Checker on the opv_validate ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "opv_consts.vh"
module opv_checker #(
	parameter CW = 16
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Descriptor and config
	input wire logic frm_valid_i,
	input wire logic frm_is_rx_i,
	input wire logic level_bypass_enable_i,
	input wire logic [1:0] frame_kind_field_i,
	input wire logic tx_valid_pdu_i,
	input wire logic [2:0] pdu_level_i,
	input wire logic [2:0] endpoint_level_i,
	input wire logic high_level_block_enable_i,
	input wire logic [`OPV_NFLAGS-1:0] flag_clear_i,
	input wire logic [`OPV_NFLAGS-1:0] intr_enable_i,
	// Verdict and status
	input wire logic res_valid_o,
	input wire logic [2:0] result_o,
	input wire logic [`OPV_NFLAGS-1:0] flags_o,
	input wire logic intr_o,
	input wire logic [CW-1:0] tx_discard_count_o,
	input wire logic [CW-1:0] rx_discard_count_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic oam;
	assign oam = frm_valid_i && !level_bypass_enable_i && frame_kind_field_i == `OPV_KIND_Y1731;
	bypass_data_a: assert property (frm_valid_i && level_bypass_enable_i |=> result_o == `OPV_RES_DATA)
		else $error("bypassed frame not data");
	kind_data_a: assert property (frm_valid_i && !level_bypass_enable_i
		&& frame_kind_field_i != `OPV_KIND_Y1731 |=> result_o == `OPV_RES_DATA) else $error("non-OAM kind not data");
	high_block_a: assert property (oam && frm_is_rx_i && pdu_level_i > endpoint_level_i |=> result_o ==
		($past(high_level_block_enable_i) ? `OPV_RES_DISCARD : `OPV_RES_DATA)) else $error("high level verdict");
	low_block_a: assert property (oam && frm_is_rx_i && pdu_level_i < endpoint_level_i
		|=> result_o == `OPV_RES_DISCARD) else $error("low level not discarded");
	tx_reject_a: assert property (oam && !frm_is_rx_i && !tx_valid_pdu_i |=> result_o == `OPV_RES_DISCARD
		&& tx_discard_count_o == $past(tx_discard_count_o) + 1'b1) else $error("tx reject");
	rx_count_a: assert property (res_valid_o && result_o == `OPV_RES_DISCARD && $past(frm_is_rx_i)
		|-> rx_discard_count_o == $past(rx_discard_count_o) + 1'b1) else $error("rx discard count");
	flag_hold_a: assert property (##1 ($past(flags_o) & ~$past(flag_clear_i) & ~flags_o) == '0)
		else $error("flag dropped without clear");
	intr_or_a: assert property ($stable(intr_enable_i) |-> intr_o == |(flags_o & intr_enable_i))
		else $error("interrupt not OR of enabled flags");
	cover property (res_valid_o && result_o == `OPV_RES_VALID);
	cover property (res_valid_o && result_o == `OPV_RES_DISCARD);
	cover property (intr_o);
endmodule // opv_checker
bind opv_validate opv_checker #(.CW(CW)) chk (.mclk_i, .rst_i, .frm_valid_i, .frm_is_rx_i, .level_bypass_enable_i,
	.frame_kind_field_i, .tx_valid_pdu_i, .pdu_level_i, .endpoint_level_i, .high_level_block_enable_i,
	.flag_clear_i, .intr_enable_i, .res_valid_o, .result_o, .flags_o, .intr_o, .tx_discard_count_o,
	.rx_discard_count_o);
`default_nettype wire

//--- bench/opv_lookup_model.sv
// Lookup pipeline model: one packed row becomes a one-cycle descriptor.
// Assumes go_i is set just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module opv_lookup_model (
	// Clock
	input wire logic mclk_i,
	// Request
	input wire logic go_i,
	input wire logic [23:0] row_i,
	// Descriptor
	output logic frm_valid_o,
	output logic [23:0] desc_o
);
	// Idle fields show the inverse, so stale values never pass
	always @(posedge mclk_i)
	begin
		frm_valid_o <= go_i;
		desc_o <= go_i ? row_i : ~row_i;
	end
endmodule // opv_lookup_model
`default_nettype wire

//--- bench/opv_validate_tb.sv
// Testbench for opv_validate: frame table, then counters, flags and level setting.
// Assumes the lookup model feeds one descriptor per request.
`timescale 1ns/1ps
`default_nettype none
`include "opv_consts.vh"
module opv_validate_tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic go = 1'b0;
	logic hb = 1'b1;
	logic [23:0] row = 24'h0;
	logic [`OPV_NFLAGS-1:0] clr = '0;
	// Descriptor fields and settings held in variables so later cases can move them
	logic [4:0] ver = 5'h0;
	logic gen = 1'b0;
	logic [2:0] prio = 3'h0;
	logic [383:0] grp = '0;
	logic [7:0] tlv = 8'h0;
	logic [2:0] elvl = 3'h3;
	logic [1:0] msel = 2'h1;
	logic [47:0] mcm = 48'h0;
	logic [47:0] ucm = 48'hA;
	logic vchk = 1'b1;
	logic [31:0] vacc = 32'h1;
	logic ccm_only = 1'b0;
	logic hw = 1'b1;
	logic gchk = 1'b1;
	logic pchk = 1'b1;
	logic [12:0] peer = 13'h5;
	logic [2:0] eint = 3'h4;
	logic [2:0] eprio = 3'h0;
	logic [`OPV_NFLAGS-1:0] ext = 12'hFFF;
	logic rearm = 1'b0;
	logic [`OPV_NFLAGS-1:0] ien = 12'h2;
	logic [23:0] d;
	logic fv;
	logic rv;
	logic [2:0] res;
	logic [`OPV_NFLAGS-1:0] fl;
	logic irq;
	logic [15:0] txc;
	logic [15:0] rxc;
	logic [15:0] lvc;
	logic [15:0] pic;
	int fail_count = 0;
	int n_checks = 0;
	// rx,bypass,kind,txok,level,opcode,interval,bad peer,bad mac,verdict
	logic [23:0] rows [0:12] = '{24'hD50180, 24'hA30180, 24'h950182, 24'h920182, 24'h930102, 24'h930192,
		24'h930181, 24'h93018A, 24'h935583, 24'h930581, 24'h130182, 24'h1B0181, 24'h230180};
	always #2.5 mclk_i = ~mclk_i;
	opv_lookup_model lkp (.mclk_i(mclk_i), .go_i(go), .row_i(row), .frm_valid_o(fv), .desc_o(d));
	opv_validate #(.CW(16)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .frm_valid_i(fv), .frm_is_rx_i(d[23]),
		.level_bypass_enable_i(d[22]), .frame_kind_field_i(d[21:20]), .tx_valid_pdu_i(d[19]),
		.pdu_level_i(d[18:16]), .pdu_opcode_i(d[15:8]), .pdu_version_i(ver), .pdu_generic_i(gen),
		.pdu_dmac_i(ucm ^ {47'h0, d[3]}), .pdu_interval_i(d[7:5]), .pdu_priority_i(prio),
		.pdu_peer_id_i(peer ^ {12'h0, d[4]}), .pdu_group_id_i(grp), .pdu_tlv_type_i(tlv),
		.endpoint_level_i(elvl), .high_level_block_enable_i(hb), .dest_mac_check_select_i(msel),
		.mc_mac_i(mcm), .uc_mac_i(ucm), .version_check_enable_i(vchk), .ver_accept_i(vacc),
		.error_report_ccm_only_i(ccm_only), .ccm_hw_enable_i(hw), .group_id_check_enable_i(gchk),
		.peer_id_check_enable_i(pchk), .group_id_cfg_i(grp), .peer_id_cfg_i(peer),
		.expected_ccm_interval_i(eint), .expected_ccm_priority_i(eprio), .extract_enable_i(ext),
		.tlv_rearm_i(rearm), .flag_clear_i(clr), .intr_enable_i(ien), .res_valid_o(rv), .result_o(res),
		.cpu_error_queue_o(), .cpu_continuity_queue_o(), .loc_clear_o(), .flags_o(fl), .last_result_o(),
		.intr_o(irq), .tx_discard_count_o(txc), .rx_discard_count_o(rxc), .level_discard_count_o(lvc),
		.interval_mismatch_count_o(), .group_id_error_count_o(), .peer_id_error_count_o(pic));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Model adds a cycle, design one more
	task automatic frame(input logic [23:0] r);
		@(posedge mclk_i);
		go <= 1'b1;
		row <= r;
		@(posedge mclk_i);
		go <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk({12'h0, rv, res}, {13'h1, r[2:0]});
	endtask
	initial
	begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk({4'h0, fl}, 16'h0);
		foreach (rows[i])
			frame(rows[i]);
		@(posedge mclk_i);
		hb <= 1'b0;
		frame(24'h950180);
		chk(rxc, 16'd5);
		chk(txc, 16'd1);
		chk(lvc, 16'd2);
		chk(pic, 16'd1);
		chk({15'h0, irq}, 16'h1);
		@(posedge mclk_i);
		clr <= '1;
		@(posedge mclk_i);
		clr <= '0;
		@(posedge mclk_i);
		#1;
		chk({3'h0, irq, fl}, 16'h0);
		// No accepted version: a clean CCM is blocked
		@(posedge mclk_i);
		vacc <= 32'h0;
		frame(24'h930182);
		// Select none: a foreign MAC still passes
		@(posedge mclk_i);
		vacc <= 32'h1;
		msel <= 2'h0;
		frame(24'h930189);
		tally_and_finish();
	end
	// Whole run is under 100 cycles; ten times that is a hang
	initial
	begin
		#5000;
		fail_count++;
		tally_and_finish();
	end
endmodule // opv_validate_tb
`default_nettype wire
